// ==== hdl/acles_defines.svh ====
// Constants for the per-port ACL entry staging registers
// Function
// - Each port keeps a 16-bit cascade member mask where bit n marks list entry n as a rule-set member.
// - The member mask is split into a high byte at offset 0x0c and a low byte at offset 0x0d, both read/write and reset to zero.
// - Select pattern 010 in bits 7 to 5 plus a port number in bits 3 to 0 of the indirect select register routes access to that port's ACL space.
// - The indirect offset register picks the ACL location whose byte is read or written through the indirect data register at 0xa0.
// - A 14-bit entry byte select mask sits with bits 13 to 8 at offset 0x10 and bits 7 to 0 at offset 0x11, both reset to zero.
// - A set select bit includes its entry byte in the next table read or write and a clear bit excludes it.
// - Select bit k governs entry byte 0x0d minus k, so bit 0 is byte 0x0d and bit 13 is byte 0x00.
// - The two top bits of the high select location read zero and are read-only; only bits 5 to 0 are writable.
// - A transfer is requested at offset 0x12 where bit 4 selects write when one and bits 3 to 0 give the entry index.
`ifndef ACLES_DEFINES_SVH
`define ACLES_DEFINES_SVH
`define ACLES_NUM_PORTS 4
`define ACLES_NUM_ENTRIES 16
`define ACLES_ENTRY_BYTES 14
`define ACLES_SEL_ADDR 8'h6e
`define ACLES_OFS_ADDR 8'h6f
`define ACLES_DATA_ADDR 8'ha0
`define ACLES_SEL_ACL 3'h2
`define ACLES_OFS_MEMBER_HI 8'h0c
`define ACLES_OFS_MEMBER_LO 8'h0d
`define ACLES_OFS_SELECT_HI 8'h10
`define ACLES_OFS_SELECT_LO 8'h11
`define ACLES_OFS_CONTROL 8'h12
`define ACLES_CTRL_WRITE_BIT 4
`define ACLES_SELECT_HI_MASK 8'h3f
`define ACLES_RESET_BYTE 8'h00
`endif

// ==== hdl/acles_pkg.sv ====
// Types for the ACL entry staging registers
package acles_pkg;
  typedef logic [7:0] acles_byte_t;
  typedef enum logic [1:0] {ACLES_IDLE, ACLES_XFER} acles_state_e;
endpackage : acles_pkg

// ==== hdl/acles_port_stage.sv ====
// Staging byte file of one port: entry bytes, select mask and control
`timescale 1ns/10ps
`include "acles_defines.svh"
module acles_port_stage
  import acles_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] ofs_in,
  input wire logic [7:0] wdata_in,
  input wire logic load_in,
  input wire logic [111:0] load_data_in,
  output logic [7:0] rdata_out,
  output logic [111:0] stage_out,
  output logic [13:0] byte_select_out,
  output logic [7:0] control_out
);
  typedef struct packed {
    logic [13:0][7:0] stage;
    logic [13:0] sel;
    logic [7:0] ctrl;
  } acles_stage_s;
  acles_stage_s st_r;
  acles_stage_s st_nxt;
  logic [111:0] merged;

  // Bytes left unselected keep their staged value on a table read
  genvar gi;
  generate
    for (gi = 0; gi < `ACLES_ENTRY_BYTES; gi++)
    begin : g_merge
      assign merged[gi*8 +: 8] = st_r.sel[13-gi] ? load_data_in[gi*8 +: 8] :
        st_r.stage[gi];
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    if (load_in)
      st_nxt.stage = merged;
    if (wr_in)
    begin
      if (ofs_in < 8'(`ACLES_ENTRY_BYTES))
        st_nxt.stage[ofs_in[3:0]] = wdata_in;
      else if (ofs_in == `ACLES_OFS_SELECT_HI)
        st_nxt.sel[13:8] = wdata_in[5:0];
      else if (ofs_in == `ACLES_OFS_SELECT_LO)
        st_nxt.sel[7:0] = wdata_in;
      else if (ofs_in == `ACLES_OFS_CONTROL)
        st_nxt.ctrl = {3'h0, wdata_in[4:0]};
    end
    if (rst_in)
    begin
      st_nxt.stage = '0;
      st_nxt.sel = '0;
      st_nxt.ctrl = `ACLES_RESET_BYTE;
    end
  end

  always_ff @(posedge core_clk_in)
    st_r <= st_nxt;

  always_comb
  begin
    rdata_out = 8'h00;
    if (ofs_in < 8'(`ACLES_ENTRY_BYTES))
      rdata_out = st_r.stage[ofs_in[3:0]];
    else if (ofs_in == `ACLES_OFS_SELECT_HI)
      rdata_out = {2'b00, st_r.sel[13:8]};
    else if (ofs_in == `ACLES_OFS_SELECT_LO)
      rdata_out = st_r.sel[7:0];
  end

  assign stage_out = st_r.stage;
  assign byte_select_out = st_r.sel;
  assign control_out = st_r.ctrl;
endmodule : acles_port_stage

// ==== hdl/acl_entry_staging_regs.sv ====
// Indirect access front end and entry table of the ACL staging registers
`timescale 1ns/10ps
`include "acles_defines.svh"
module acl_entry_staging_regs
  import acles_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [3:0] port_cascade_member_bit_out,
  output logic [15:0] cascade_member_mask_out,
  output logic xfer_busy_out
);
  typedef struct packed {
    logic [7:0] select;
    logic [7:0] offset;
    logic [7:0] rdata;
    acles_state_e state;
    logic [1:0] port;
    logic write;
    logic [3:0] entry_index;
  } acles_top_s;
  acles_top_s t_r;
  acles_top_s t_nxt;

  logic [15:0][111:0] table_mem [`ACLES_NUM_PORTS];
  logic [3:0] stage_wr;
  logic [3:0] stage_load;
  logic [3:0][7:0] stage_rdata;
  logic [3:0][111:0] stage_data;
  logic [3:0][13:0] stage_sel;
  logic [3:0][7:0] stage_ctrl;
  logic acl_space;
  logic data_wr;
  logic [1:0] port_idx;
  logic [111:0] wr_word;
  logic [7:0] status_byte;

  assign acl_space = (t_r.select[7:5] == `ACLES_SEL_ACL) &&
    (t_r.select[3:0] >= 4'h1) && (t_r.select[3:0] <= 4'h4);
  assign port_idx = 2'(t_r.select[3:0] - 4'h1);
  assign data_wr = reg_wr_in && (reg_addr_in == `ACLES_DATA_ADDR) && acl_space;

  genvar gp;
  generate
    for (gp = 0; gp < `ACLES_NUM_PORTS; gp++)
    begin : g_port
      assign stage_wr[gp] = data_wr && (port_idx == 2'(gp));
      assign stage_load[gp] = (t_r.state == ACLES_XFER) && !t_r.write &&
        (t_r.port == 2'(gp));
      acles_port_stage acles_port_stage_inst (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_in(stage_wr[gp]),
        .ofs_in(t_r.offset),
        .wdata_in(reg_wdata_in),
        .load_in(stage_load[gp]),
        .load_data_in(table_mem[gp][t_r.entry_index]),
        .rdata_out(stage_rdata[gp]),
        .stage_out(stage_data[gp]),
        .byte_select_out(stage_sel[gp]),
        .control_out(stage_ctrl[gp])
      );
    end
  endgenerate

  // Member mask of the port under access: high byte staged at 0x0c, low at 0x0d
  assign cascade_member_mask_out = {stage_data[port_idx][103:96],
    stage_data[port_idx][111:104]};
  assign port_cascade_member_bit_out = 4'(port_idx);

  // Write merge keeps unselected bytes of the stored entry
  assign status_byte = {1'b0, (t_r.state == ACLES_IDLE) || !t_r.write,
    (t_r.state == ACLES_IDLE) || t_r.write, 5'h00};
  genvar gb;
  generate
    for (gb = 0; gb < `ACLES_ENTRY_BYTES; gb++)
    begin : g_wmerge
      assign wr_word[gb*8 +: 8] = stage_sel[t_r.port][13-gb] ?
        stage_data[t_r.port][gb*8 +: 8] :
        table_mem[t_r.port][t_r.entry_index][gb*8 +: 8];
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if ((t_r.state == ACLES_XFER) && t_r.write)
      table_mem[t_r.port][t_r.entry_index] <= wr_word;
  end

  always_comb
  begin
    t_nxt = t_r;
    t_nxt.state = ACLES_IDLE;
    if (reg_wr_in && (reg_addr_in == `ACLES_SEL_ADDR))
      t_nxt.select = reg_wdata_in;
    if (reg_wr_in && (reg_addr_in == `ACLES_OFS_ADDR))
      t_nxt.offset = reg_wdata_in;
    // Transfer takes one cycle, so status reads complete at the next access
    if (data_wr && (t_r.offset == `ACLES_OFS_CONTROL))
    begin
      t_nxt.state = ACLES_XFER;
      t_nxt.port = port_idx;
      t_nxt.write = reg_wdata_in[`ACLES_CTRL_WRITE_BIT];
      t_nxt.entry_index = reg_wdata_in[3:0];
    end
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        `ACLES_SEL_ADDR: t_nxt.rdata = t_r.select;
        `ACLES_OFS_ADDR: t_nxt.rdata = t_r.offset;
        `ACLES_DATA_ADDR:
        begin
          if (!acl_space)
            t_nxt.rdata = 8'h00;
          else if (t_r.offset == `ACLES_OFS_CONTROL)
            t_nxt.rdata = status_byte | stage_ctrl[port_idx];
          else
            t_nxt.rdata = stage_rdata[port_idx];
        end
        default: t_nxt.rdata = 8'h00;
      endcase
    end
    if (rst_in)
    begin
      t_nxt.select = `ACLES_RESET_BYTE;
      t_nxt.offset = `ACLES_RESET_BYTE;
      t_nxt.rdata = `ACLES_RESET_BYTE;
      t_nxt.state = ACLES_IDLE;
      t_nxt.port = 2'h0;
      t_nxt.write = 1'b0;
      t_nxt.entry_index = 4'h0;
    end
  end

  always_ff @(posedge core_clk_in)
    t_r <= t_nxt;

  assign reg_rdata_out = t_r.rdata;
  assign xfer_busy_out = (t_r.state == ACLES_XFER);
endmodule : acl_entry_staging_regs

// ==== tb/acles_checker_asserts.sv ====
// Port-level checker for the ACL staging register front end
`timescale 1ns/10ps
module acles_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [3:0] port_cascade_member_bit_out,
  input wire logic [15:0] cascade_member_mask_out,
  input wire logic xfer_busy_out
);
  logic [7:0] sel_r;
  logic [7:0] ofs_r;
  logic ok;
  logic rda;
  assign ok = sel_r[7:5] == 3'h2 && sel_r[3:0] >= 4'h1 && sel_r[3:0] <= 4'h4;
  assign rda = reg_rd_in && reg_addr_in == 8'ha0;
  // Shadow of select and offset so data reads can be judged
  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      sel_r <= 8'h00;
      ofs_r <= 8'h00;
    end
    else if (reg_wr_in && reg_addr_in == 8'h6e)
      sel_r <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == 8'h6f)
      ofs_r <= reg_wdata_in;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_busy_one_cycle: assert property (xfer_busy_out |=> !xfer_busy_out)
    else $error("busy too long");
  a_busy_has_cause: assert property ($rose(xfer_busy_out) |->
    $past(reg_wr_in && reg_addr_in == 8'ha0 && ok && ofs_r == 8'h12)) else $error("stray busy");
  a_rdata_held: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved");
  a_port_index: assert property (ok |-> port_cascade_member_bit_out == sel_r[3:0] - 4'h1)
    else $error("port index wrong");
  a_bad_select_zero: assert property (rda && !ok |=> reg_rdata_out == 8'h00)
    else $error("bad select read");
  a_unmapped_zero: assert property (rda && ok && (ofs_r inside {8'h0e, 8'h0f}
    || ofs_r > 8'h12) |=> reg_rdata_out == 8'h00) else $error("unmapped read");
  a_select_rsvd: assert property (rda && ok && ofs_r == 8'h10 |=> !reg_rdata_out[7:6])
    else $error("reserved bits set");
  a_status_done: assert property (rda && ok && ofs_r == 8'h12 && !xfer_busy_out
    |=> reg_rdata_out[7:5] == 3'h3) else $error("status bits wrong");
endmodule : acles_checker
bind acl_entry_staging_regs acles_checker acles_checker_inst (
  .core_clk_in(core_clk_in),
  .rst_in(rst_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .port_cascade_member_bit_out(port_cascade_member_bit_out),
  .cascade_member_mask_out(cascade_member_mask_out),
  .xfer_busy_out(xfer_busy_out)
);

// ==== tb/acl_entry_staging_regs_bench.sv ====
// Random and corner-case bench for the ACL staging registers
`timescale 1ns/10ps
module acl_entry_staging_regs_bench;
  logic core_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic [3:0] port_cascade_member_bit_out;
  logic [15:0] cascade_member_mask_out;
  logic xfer_busy_out;
  int n_errors = 0;
  int checks_done = 0;
  int seed = 82;
  int cyc = 0;
  logic [7:0] tbl [14];
  logic [13:0] m;
  logic [3:0] e;
  logic [7:0] v;
  acl_entry_staging_regs acl_entry_staging_regs_inst (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .port_cascade_member_bit_out(port_cascade_member_bit_out),
    .cascade_member_mask_out(cascade_member_mask_out),
    .xfer_busy_out(xfer_busy_out)
  );
  always #50 core_clk_in = ~core_clk_in;
  task automatic chk(input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x)
      $display("Error %0t: saw %h expected %h", $time, s, x);
    if (s !== x)
      n_errors++;
  endtask : chk
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge core_clk_in);
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h0;
  endtask : op
  task automatic wb(input logic [7:0] o, input logic [7:0] d);
    op(1'h1, 8'h6f, o);
    op(1'h1, 8'ha0, d);
  endtask : wb
  task automatic rb(input logic [7:0] o, input logic [7:0] x);
    op(1'h1, 8'h6f, o);
    op(1'h0, 8'ha0, 8'h00);
    chk(reg_rdata_out, x);
  endtask : rb
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  always @(posedge core_clk_in)
  begin
    cyc++;
    // Whole run needs about 1400 cycles
    if (cyc == 8000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(negedge core_clk_in);
    rst_in = 1'h0;
    for (int i = 0; i < 4; i++)
    begin
      op(1'h1, 8'h6e, {4'h2, 4'(i + 1)});
      rb(8'h0c, 8'h00);
      op(1'h1, 8'h6e, {4'h4, 4'(i + 1)});
      chk(8'(port_cascade_member_bit_out), 8'(i));
      foreach (tbl[b]) rb(8'(b), 8'h00);
      rb(8'h11, 8'h00);
      wb(8'h10, 8'hff);
      rb(8'h10, 8'h3f);
      rb(8'h0e, 8'h00);
      e = 4'($random(seed));
      foreach (tbl[b])
      begin
        tbl[b] = 8'($random(seed));
        wb(8'(b), tbl[b]);
      end
      chk(cascade_member_mask_out[15:8], tbl[12]);
      chk(cascade_member_mask_out[7:0], tbl[13]);
      wb(8'h11, 8'hff);
      wb(8'h12, {4'h1, e});
      m = 14'($random(seed));
      wb(8'h10, {2'h0, m[13:8]});
      wb(8'h11, m[7:0]);
      // Partial write: unselected bytes must survive in the table
      foreach (tbl[b])
      begin
        v = 8'($random(seed));
        wb(8'(b), v);
        if (m[13 - b])
          tbl[b] = v;
      end
      wb(8'h12, {4'h1, e});
      foreach (tbl[b]) wb(8'(b), 8'h00);
      m = 14'($random(seed));
      wb(8'h10, {2'h0, m[13:8]});
      wb(8'h11, m[7:0]);
      wb(8'h12, {4'h0, e});
      rb(8'h12, {4'h6, e});
      foreach (tbl[b]) rb(8'(b), m[13 - b] ? tbl[b] : 8'h00);
      chk(cascade_member_mask_out[7:0], m[0] ? tbl[13] : 8'h00);
    end
    summarize();
  end
endmodule : acl_entry_staging_regs_bench
